//--- converter_trim_register_bank.sv
// AXI4-Lite register bank holding the core-B offset and dual-channel fine-gain trims.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// Function
// - Core B sampling input A with calibration on gets the input A offset word.
// - Core B sampling input B with calibration on gets the input B offset word.
// - Offset words load from fuse storage and hold until software overwrites them.
// - Core A bank 0 five-bit fine gain applies in dual-channel operation with calibration on.
// - Core A bank 1 five-bit fine gain applies in dual-channel operation with calibration on.
// - Core B bank 0 five-bit fine gain applies in dual-channel operation with calibration on.
// - Fine-gain words load from fuse storage instead of the reset value.
module converter_trim_register_bank
    import trim_bank_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire fuse_s             fuse_values,
    input  wire logic              fg_cal_enable,
    input  wire logic              dual_channel_mode,
    input  wire logic              core_b_samples_input_b,
    output trim_s                  trim_out
);

    // The highest register byte address needs twelve bits; the bus word caps it at 32.
    if (ADDR_W < 12 || ADDR_W > 32) begin : gen_addr_w_check
        $error("ADDR_W must lie between 12 and 32.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and the write path.
    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        idx = addr >> BYTE_ADDR_SHIFT;
        decode = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (idx == ADDR_W'(IDX_CORE_B_OFFSET_INPUT_A)) begin
                decode = SEL_OFFSET_A;
            end else if (idx == ADDR_W'(IDX_CORE_B_OFFSET_INPUT_B)) begin
                decode = SEL_OFFSET_B;
            end else if (idx == ADDR_W'(IDX_CORE_A_BANK0_DUAL_GAIN)) begin
                decode = SEL_GAIN_A0;
            end else if (idx == ADDR_W'(IDX_CORE_A_BANK1_DUAL_GAIN)) begin
                decode = SEL_GAIN_A1;
            end else if (idx == ADDR_W'(IDX_CORE_B_BANK0_DUAL_GAIN)) begin
                decode = SEL_GAIN_B0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Fuse preload. Reset only takes constants; the fuse image is copied in the
    // first cycle after release, and the bus is held off until then.
    logic preload_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            preload_q <= 1'b1;
        end else begin
            preload_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are caught independently, in either order.
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              wr_fire;
    reg_sel_e          wr_sel;

    assign s_axi_awready = !aw_held_q && !preload_q;
    assign s_axi_wready  = !w_held_q && !preload_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel        = decode(aw_addr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage. Reserved upper bits are stored as written.
    logic [15:0] offset_a_q;
    logic [15:0] offset_b_q;
    logic [7:0]  gain_q [3];

    // Byte-lane merge for a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? d[15:8] : old_v[15:8], strb[0] ? d[7:0] : old_v[7:0]};
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offset_a_q <= OFFSET_REG_RST;
            offset_b_q <= OFFSET_REG_RST;
        end else if (preload_q) begin
            offset_a_q <= fuse_values.core_b_offset_input_a;
            offset_b_q <= fuse_values.core_b_offset_input_b;
        end else if (wr_fire && wr_sel == SEL_OFFSET_A) begin
            offset_a_q <= merge16(offset_a_q, w_data_q, w_strb_q);
        end else if (wr_fire && wr_sel == SEL_OFFSET_B) begin
            offset_b_q <= merge16(offset_b_q, w_data_q, w_strb_q);
        end
    end

    // Bank 0 of core A, bank 1 of core A, bank 0 of core B, in that order.
    logic [7:0] gain_fuse [3];
    assign gain_fuse[0] = fuse_values.core_a_bank0_dual_gain;
    assign gain_fuse[1] = fuse_values.core_a_bank1_dual_gain;
    assign gain_fuse[2] = fuse_values.core_b_bank0_dual_gain;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_gain
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    gain_q[g] <= GAIN_REG_RST;
                end else if (preload_q) begin
                    gain_q[g] <= gain_fuse[g];
                end else if (wr_fire && wr_sel == reg_sel_e'(3'(g) + 3'h3) && w_strb_q[0]) begin
                    gain_q[g] <= w_data_q[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, answered the cycle after the address is taken.
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    reg_sel_e    rd_sel;

    assign s_axi_arready = !rvalid_q && !preload_q;
    assign rd_sel        = decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= RDATA_UNMAPPED;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            case (rd_sel)
                SEL_OFFSET_A: rdata_q <= {16'h0000, offset_a_q};
                SEL_OFFSET_B: rdata_q <= {16'h0000, offset_b_q};
                SEL_GAIN_A0:  rdata_q <= {24'h000000, gain_q[0]};
                SEL_GAIN_A1:  rdata_q <= {24'h000000, gain_q[1]};
                SEL_GAIN_B0:  rdata_q <= {24'h000000, gain_q[2]};
                default: begin
                    rdata_q <= RDATA_UNMAPPED;
                    rresp_q <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Trim outputs. Registered so that a write reaches the cores one cycle later,
    // which is before any conversion that follows the bus response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_out <= '0;
        end else begin
            if (!fg_cal_enable) begin
                trim_out.core_b_offset_trim <= '0;
            end else if (core_b_samples_input_b) begin
                trim_out.core_b_offset_trim <= offset_b_q[OFFSET_TRIM_W-1:0];
            end else begin
                trim_out.core_b_offset_trim <= offset_a_q[OFFSET_TRIM_W-1:0];
            end
            if (fg_cal_enable && dual_channel_mode) begin
                trim_out.core_a_bank0_fine_gain <= gain_q[0][GAIN_TRIM_W-1:0];
                trim_out.core_a_bank1_fine_gain <= gain_q[1][GAIN_TRIM_W-1:0];
                trim_out.core_b_bank0_fine_gain <= gain_q[2][GAIN_TRIM_W-1:0];
            end else begin
                trim_out.core_a_bank0_fine_gain <= '0;
                trim_out.core_a_bank1_fine_gain <= '0;
                trim_out.core_b_bank0_fine_gain <= '0;
            end
        end
    end

endmodule

//--- trim_bank_pkg.sv
// Constants, register map and carrier types of the converter trim register bank.
package trim_bank_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address of each register is four times its index.
    localparam logic [11:0] IDX_CORE_B_OFFSET_INPUT_A = 12'h34C;
    localparam logic [11:0] IDX_CORE_B_OFFSET_INPUT_B = 12'h34E;
    localparam logic [11:0] IDX_CORE_A_BANK0_DUAL_GAIN = 12'h350;
    localparam logic [11:0] IDX_CORE_A_BANK1_DUAL_GAIN = 12'h351;
    localparam logic [11:0] IDX_CORE_B_BANK0_DUAL_GAIN = 12'h352;
    localparam int unsigned BYTE_ADDR_SHIFT            = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Field layout and reset values.
    localparam int unsigned OFFSET_REG_W   = 16;
    localparam int unsigned OFFSET_TRIM_W  = 12;
    localparam int unsigned GAIN_REG_W     = 8;
    localparam int unsigned GAIN_TRIM_W    = 5;
    localparam logic [15:0] OFFSET_REG_RST = 16'h0000;
    localparam logic [7:0]  GAIN_REG_RST   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answers.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;

    typedef enum logic [2:0] {
        SEL_NONE     = 3'b000,
        SEL_OFFSET_A = 3'b001,
        SEL_OFFSET_B = 3'b010,
        SEL_GAIN_A0  = 3'b011,
        SEL_GAIN_A1  = 3'b100,
        SEL_GAIN_B0  = 3'b101
    } reg_sel_e;

    // Full register images, as preloaded from fuse storage.
    typedef struct packed {
        logic [15:0] core_b_offset_input_a;
        logic [15:0] core_b_offset_input_b;
        logic [7:0]  core_a_bank0_dual_gain;
        logic [7:0]  core_a_bank1_dual_gain;
        logic [7:0]  core_b_bank0_dual_gain;
    } fuse_s;

    // Trim words handed to the converter cores.
    typedef struct packed {
        logic [11:0] core_b_offset_trim;
        logic [4:0]  core_a_bank0_fine_gain;
        logic [4:0]  core_a_bank1_fine_gain;
        logic [4:0]  core_b_bank0_fine_gain;
    } trim_s;

endpackage

//--- trim_bank_checker.sv
// Port assertions for the converter trim register bank.
`timescale 1ns/10ps
module trim_bank_checker
    import trim_bank_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              fg_cal_enable,
    input wire logic              dual_channel_mode,
    input wire trim_s             trim_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence wr_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // The trims lag the mode inputs by one cycle, so the gate is judged on the past value.
    offset_gate_a: assert property (
        !$past(fg_cal_enable) |-> trim_out.core_b_offset_trim == 12'h000)
        else $error("Offset trim applied with calibration off.");
    gain_gate_a: assert property (
        !($past(fg_cal_enable) && $past(dual_channel_mode)) |-> trim_out[14:0] == 15'h0000)
        else $error("Fine gain applied outside dual calibrated mode.");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("Read answer late.");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read answer dropped before accepted.");
    read_refuse_a: assert property (
        rd_take ##0 s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == RDATA_UNMAPPED)
        else $error("Misaligned read not refused.");
    // Both halves are held at the taking edge and stored one edge later, so the
    // response is first visible two edges after the pair is taken.
    write_answer_a: assert property (wr_pair |-> ##2 s_axi_bvalid)
        else $error("Write answer late.");
    write_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write answer dropped before accepted.");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address accepted while answer pending.");
endmodule
bind converter_trim_register_bank trim_bank_checker #(.ADDR_W(ADDR_W)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fg_cal_enable, .dual_channel_mode, .trim_out
);

//--- tb_top.sv
// Self-checking bench for the converter trim register bank.
`timescale 1ns/10ps
module tb_top
    import trim_bank_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, fg_cal_enable, dual_channel_mode, core_b_samples_input_b;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    fuse_s       fuse_values;
    trim_s       trim_out;
    logic [15:0] m_off [2];
    logic [7:0]  m_gain [3];
    logic [11:0] addr_tbl [5] = '{12'hD30, 12'hD38, 12'hD40, 12'hD44, 12'hD48};
    int          err_count = 0, n_tests = 0, cyc = 0;

    converter_trim_register_bank dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fuse_values,
        .fg_cal_enable, .dual_channel_mode, .core_b_samples_input_b, .trim_out
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] cur(input int i);
        return (i < 2) ? {16'h0000, m_off[i]} : {24'h000000, m_gain[i-2]};
    endfunction

    function automatic logic [31:0] exp_trim();
        trim_s t;
        t = '0;
        if (fg_cal_enable) t.core_b_offset_trim = m_off[core_b_samples_input_b][11:0];
        if (fg_cal_enable && dual_channel_mode) begin
            t.core_a_bank0_fine_gain = m_gain[0][4:0];
            t.core_a_bank1_fine_gain = m_gain[1][4:0];
            t.core_b_bank0_fine_gain = m_gain[2][4:0];
        end
        return {5'h00, t};
    endfunction

    // Answer ready is offered with the request and held until the answer is taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic hs_aw, hs_w, hs_b;
        hs_b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hs_b) begin
            @(negedge aclk);
            hs_aw = s_axi_awvalid && s_axi_awready;
            hs_w = s_axi_wvalid && s_axi_wready;
            hs_b = s_axi_bvalid && s_axi_bready;
            if (hs_b) cmp({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge aclk);
            if (hs_aw) s_axi_awvalid <= 1'b0;
            if (hs_w) s_axi_wvalid <= 1'b0;
            if (hs_b) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic hs_ar, hs_r;
        hs_r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hs_r) begin
            @(negedge aclk);
            hs_ar = s_axi_arvalid && s_axi_arready;
            hs_r = s_axi_rvalid && s_axi_rready;
            if (hs_r) cmp(s_axi_rdata, ed);
            if (hs_r) cmp({30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge aclk);
            if (hs_ar) s_axi_arvalid <= 1'b0;
            if (hs_r) s_axi_rready <= 1'b0;
        end
    endtask

    task automatic mode(input logic f, input logic d, input logic b);
        @(posedge aclk);
        fg_cal_enable <= f;
        dual_channel_mode <= d;
        core_b_samples_input_b <= b;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        cmp({5'h00, trim_out}, exp_trim());
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {fg_cal_enable, dual_channel_mode, core_b_samples_input_b} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        fuse_values = {16'hA5C3, 16'h3E71, 8'hE9, 8'h76, 8'hB4};
        m_off = '{16'hA5C3, 16'h3E71};
        m_gain = '{8'hE9, 8'h76, 8'hB4};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(addr_tbl[i], cur(i), RESP_OKAY);
        for (int k = 0; k < 8; k++) mode(k[2], k[1], k[0]);
        m_off = '{16'hF123, 16'h7ABC};
        m_gain = '{8'hFF, 8'h1A, 8'hE5};
        for (int i = 0; i < 5; i++) wr(addr_tbl[i], cur(i) | 32'h5A5A0000, 4'hF, RESP_OKAY);
        for (int i = 0; i < 5; i++) rd(addr_tbl[i], cur(i), RESP_OKAY);
        mode(1'b1, 1'b1, 1'b0);
        mode(1'b1, 1'b0, 1'b1);
        wr(12'hD30, 32'h0000FF42, 4'h1, RESP_OKAY);
        m_off[0] = {m_off[0][15:8], 8'h42};
        wr(12'hD34, 32'h0000FFFF, 4'hF, RESP_DECERR);
        wr(12'hD32, 32'h0000FFFF, 4'hF, RESP_DECERR);
        rd(12'hD34, RDATA_UNMAPPED, RESP_DECERR);
        rd(12'hD31, RDATA_UNMAPPED, RESP_DECERR);
        for (int i = 0; i < 5; i++) rd(addr_tbl[i], cur(i), RESP_OKAY);
        mode(1'b1, 1'b1, 1'b0);
        // A second reset with a new fuse image must preload every word again.
        @(posedge aclk);
        aresetn <= 1'b0;
        fuse_values <= {16'h0C3A, 16'hB18E, 8'h3D, 8'h42, 8'h9F};
        m_off = '{16'h0C3A, 16'hB18E};
        m_gain = '{8'h3D, 8'h42, 8'h9F};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(addr_tbl[i], cur(i), RESP_OKAY);
        mode(1'b1, 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule
